// ---- rsmfc_ctrl.sv ----
// What this block does
// R1: A sampled-high run request moves the block to active and runs the power-up sequence.
// R2: A sampled-low run request moves the block to shutdown and runs the power-down sequence.
// R3: A low sleep input runs the sleep-entry sequence and then enters sleep.
// R4: A sleep input back high runs the sleep-exit sequence and leaves sleep.
// R5: A low emergency power-down input starts the power-down sequence.
// R6: An outside party pulling the system reset line low is a fault and raises the interrupt.
// R7: The active-low interrupt is asserted whenever any fault is recorded.
// R8: Each detected fault is recorded in flag registers the host can read.
// R9: A flag clears only when a one is written to it; a zero leaves it alone.
// R10: A flag stays set after its cause goes away until the host clears it.
// R11: Power-up slots are rails 1,2,7 in 1; rails 3,4,8 in 2; rail 5 in 3; rail 6 in 4.
// R12: Power-down slots are rails 2,6,7 in 1; rail 5 in 2; rails 3,4,8 in 3; rail 1 in 4.
// R13: Sleep-exit slots are rails 2,7 in 1; rail 6 in 2; rails 3,8 in 3; rails 1,4,5 untouched.
// R14: Sleep-entry slots are rail 6 in 1; rails 3,8 in 2; rails 2,7 in 3; rails 1,4,5 untouched.
// R15: Consecutive slots are 625 us apart.
// R16: Rails of one slot change together and slots are walked in ascending order.
// R17: Run, sleep and emergency inputs pass two flip-flops before they steer the state.
module rsmfc_ctrl #(
   parameter int unsigned SLOT_CYCLES = rsmfc_pkg::SLOT_CYC
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Mode pins
   input wire logic run_request_in,
   input wire logic sleep_n_in,
   input wire logic emergency_powerdown_n,
   // Rail enables, bit 0 is rail_enable_1
   output logic [rsmfc_pkg::RAILS-1:0] rail_enable,
   input wire logic [rsmfc_pkg::RAILS-1:0] rail_pgood,
   // Open-drain system reset line
   input wire logic system_reset_n_in,
   output logic system_reset_n_out,
   output logic system_reset_n_oe,
   // Open-drain interrupt line
   output logic fault_irq_n_out,
   output logic fault_irq_n_oe,
   // Fault flags with write-one-to-clear strobes
   output logic [7:0] fault_flags_first,
   output logic [7:0] fault_flags_second,
   input wire logic [7:0] clear_flags_first,
   input wire logic [7:0] clear_flags_second
);

   ////////////////////////////////////////////////////////////////////////////
   // Reset release
   logic rst_meta_q;
   logic rst_sync_n;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_q <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_n <= rst_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers
   rsmfc_pkg::rsmfc_ctrl_type ctl_meta_q;
   rsmfc_pkg::rsmfc_ctrl_type ctl_q;

   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ctl_meta_q <= '{run: 1'b0, sleep_n: 1'b1, emerg_n: 1'b1};
         ctl_q <= '{run: 1'b0, sleep_n: 1'b1, emerg_n: 1'b1};
      end else begin
         ctl_meta_q <= '{run: run_request_in, sleep_n: sleep_n_in,
                         emerg_n: emergency_powerdown_n}; // see R17
         ctl_q <= ctl_meta_q; // see R17
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State, slot and slot timer
   rsmfc_pkg::rsmfc_state_type state_q;
   rsmfc_pkg::rsmfc_state_type state_d;
   logic [rsmfc_pkg::SLOT_W-1:0] slot_q;
   logic [rsmfc_pkg::TMR_W-1:0] tmr_q;
   logic [rsmfc_pkg::RAILS-1:0] en_q;
   logic [rsmfc_pkg::RAILS-1:0] en_d;

   wire logic in_up = (state_q == rsmfc_pkg::ST_UP);
   wire logic in_down = (state_q == rsmfc_pkg::ST_DOWN);
   wire logic in_entry = (state_q == rsmfc_pkg::ST_SLP_IN);
   wire logic in_exit = (state_q == rsmfc_pkg::ST_SLP_OUT);
   wire logic in_seq = in_up | in_down | in_entry | in_exit;
   wire logic turn_on = in_up | in_exit;
   wire logic slot_end = (tmr_q == rsmfc_pkg::TMR_W'(SLOT_CYCLES - 1));
   wire logic [rsmfc_pkg::SLOT_W-1:0] last_slot =
      (in_entry | in_exit) ? rsmfc_pkg::SLOT_LAST_SLP : rsmfc_pkg::SLOT_LAST_PWR;
   wire logic seq_done = in_seq & slot_end & (slot_q == last_slot);
   wire logic want_down = !ctl_q.run | !ctl_q.emerg_n;
   wire rsmfc_pkg::rsmfc_pos_type pos_sel =
      in_up ? rsmfc_pkg::POS_UP :             // see R11
      in_down ? rsmfc_pkg::POS_DOWN :         // see R12
      in_exit ? rsmfc_pkg::POS_EXIT :         // see R13
      rsmfc_pkg::POS_ENTRY;                   // see R14
   logic [rsmfc_pkg::RAILS-1:0] hit;

   // Every rail whose position matches the current slot moves in one edge
   for (genvar i = 0; i < rsmfc_pkg::RAILS; i++) begin : g_rail
      assign hit[i] = in_seq & (pos_sel[i] == slot_q); // see R16
      assign en_d[i] = hit[i] ? turn_on : en_q[i];
   end

   always_comb begin
      state_d = state_q;
      case (state_q)
         rsmfc_pkg::ST_OFF: begin
            if (ctl_q.run && ctl_q.emerg_n) begin
               state_d = rsmfc_pkg::ST_UP; // see R1
            end
         end
         rsmfc_pkg::ST_UP, rsmfc_pkg::ST_SLP_OUT: begin
            if (want_down) begin
               state_d = rsmfc_pkg::ST_DOWN; // see R2 see R5
            end else if (seq_done) begin
               state_d = rsmfc_pkg::ST_ACTIVE; // see R1 see R4
            end
         end
         rsmfc_pkg::ST_ACTIVE: begin
            if (want_down) begin
               state_d = rsmfc_pkg::ST_DOWN; // see R2 see R5
            end else if (!ctl_q.sleep_n) begin
               state_d = rsmfc_pkg::ST_SLP_IN; // see R3
            end
         end
         rsmfc_pkg::ST_SLP_IN: begin
            if (want_down) begin
               state_d = rsmfc_pkg::ST_DOWN; // see R5
            end else if (seq_done) begin
               state_d = rsmfc_pkg::ST_SLEEP; // see R3
            end
         end
         rsmfc_pkg::ST_SLEEP: begin
            if (want_down) begin
               state_d = rsmfc_pkg::ST_DOWN; // see R5
            end else if (ctl_q.sleep_n) begin
               state_d = rsmfc_pkg::ST_SLP_OUT; // see R4
            end
         end
         rsmfc_pkg::ST_DOWN: begin
            // A run request in mid power-down waits for the sequence to finish
            if (seq_done) begin
               state_d = rsmfc_pkg::ST_OFF; // see R2
            end
         end
         default: begin
            state_d = rsmfc_pkg::ST_DOWN;
         end
      endcase
   end

   // Any change of state restarts at slot 1 with a fresh 625 us timer
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state_q <= rsmfc_pkg::ST_OFF;
         slot_q <= rsmfc_pkg::SLOT_FIRST;
         tmr_q <= '0;
         en_q <= '0;
      end else begin
         state_q <= state_d;
         en_q <= en_d; // see R16
         if (state_d != state_q || !in_seq || slot_end) begin
            tmr_q <= '0;
         end else begin
            tmr_q <= tmr_q + 1'b1; // see R15
         end
         if (state_d != state_q || !in_seq) begin
            slot_q <= rsmfc_pkg::SLOT_FIRST;
         end else if (slot_end) begin
            slot_q <= slot_q + 1'b1; // see R15 see R16
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fault detection and flags
   logic rst_drv_q;
   logic rst_drv_prev_q;
   logic emerg_prev_q;
   logic [7:0] flg1_q;
   logic [7:0] flg2_q;
   logic irq_q;

   // The line is checked only when we have not driven it for two cycles,
   // so our own release through the pull-up is not taken as a fault
   wire logic ext_rst = !system_reset_n_in & !rst_drv_q & !rst_drv_prev_q; // see R6
   wire logic emerg_fall = emerg_prev_q & !ctl_q.emerg_n;
   wire logic pg_check = seq_done & turn_on;
   wire logic [7:0] pg_miss = pg_check ? (en_d & ~rail_pgood) : 8'h00;
   wire logic [7:0] set1 = {5'h00, |pg_miss, emerg_fall, ext_rst};
   // Set wins over a clear in the same cycle
   wire logic [7:0] flg1_d = (flg1_q & ~clear_flags_first) | set1; // see R9 see R10
   wire logic [7:0] flg2_d = (flg2_q & ~clear_flags_second) | pg_miss; // see R9 see R10
   wire logic drv_d = (state_d == rsmfc_pkg::ST_OFF) || (state_d == rsmfc_pkg::ST_UP) ||
                      (state_d == rsmfc_pkg::ST_DOWN);

   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rst_drv_q <= 1'b1;
         rst_drv_prev_q <= 1'b1;
         emerg_prev_q <= 1'b1;
         flg1_q <= rsmfc_pkg::FLAGS_RST;
         flg2_q <= rsmfc_pkg::FLAGS_RST;
         irq_q <= 1'b0;
      end else begin
         rst_drv_q <= drv_d;
         rst_drv_prev_q <= rst_drv_q;
         emerg_prev_q <= ctl_q.emerg_n;
         flg1_q <= flg1_d; // see R8
         flg2_q <= flg2_d; // see R8
         irq_q <= |{flg1_d, flg2_d}; // see R7
      end
   end

   assign rail_enable = en_q;
   assign system_reset_n_out = 1'b0;
   assign system_reset_n_oe = rst_drv_q;
   assign fault_irq_n_out = 1'b0;
   assign fault_irq_n_oe = irq_q;
   assign fault_flags_first = flg1_q;
   assign fault_flags_second = flg2_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   property p_run_up;
      @(posedge ref_clk) disable iff (!rst_sync_n)
      state_q == rsmfc_pkg::ST_OFF && ctl_q.run && ctl_q.emerg_n |=> in_up;
   endproperty
   a_run_up: assert property (p_run_up) else $error("run request ignored"); // see R1

   property p_run_down;
      @(posedge ref_clk) disable iff (!rst_sync_n)
      state_q == rsmfc_pkg::ST_ACTIVE && !ctl_q.run |=> in_down;
   endproperty
   a_run_down: assert property (p_run_down) else $error("no power-down"); // see R2

   property p_sleep_in;
      @(posedge ref_clk) disable iff (!rst_sync_n)
      state_q == rsmfc_pkg::ST_ACTIVE && !want_down && !ctl_q.sleep_n |=>
         in_entry ##1 (in_entry || in_down);
   endproperty
   a_sleep_in: assert property (p_sleep_in) else $error("no sleep entry"); // see R3

   property p_sleep_out;
      @(posedge ref_clk) disable iff (!rst_sync_n)
      state_q == rsmfc_pkg::ST_SLEEP && !want_down && ctl_q.sleep_n |=> in_exit;
   endproperty
   a_sleep_out: assert property (p_sleep_out) else $error("no sleep exit"); // see R4

   property p_emerg;
      @(posedge ref_clk) disable iff (!rst_sync_n)
      !ctl_q.emerg_n && state_q != rsmfc_pkg::ST_OFF && !(in_down && seq_done) |=> in_down;
   endproperty
   a_emerg: assert property (p_emerg) else $error("emergency ignored"); // see R5

   property p_ext_rst;
      @(posedge ref_clk) disable iff (!rst_sync_n)
      !system_reset_n_in && !rst_drv_q && !rst_drv_prev_q |=> flg1_q[0] && fault_irq_n_oe;
   endproperty
   a_ext_rst: assert property (p_ext_rst) else $error("reset fault lost"); // see R6

   property p_irq;
      @(posedge ref_clk) disable iff (!rst_sync_n)
      $rose(|{flg1_q, flg2_q}) |-> fault_irq_n_oe;
   endproperty
   a_irq: assert property (p_irq) else $error("irq missing"); // see R7

   property p_w1c;
      @(posedge ref_clk) disable iff (!rst_sync_n)
      flg2_q[4] && !clear_flags_second[4] |=> flg2_q[4];
   endproperty
   a_w1c: assert property (p_w1c) else $error("flag lost"); // see R9 see R10

   property p_clear;
      @(posedge ref_clk) disable iff (!rst_sync_n)
      clear_flags_first[1] && !emerg_fall |=> !flg1_q[1];
   endproperty
   a_clear: assert property (p_clear) else $error("flag not cleared"); // see R9

   property p_up_slot1;
      @(posedge ref_clk) disable iff (!rst_sync_n)
      in_up && slot_q == 3'h1 && !want_down |=> en_q[0] && en_q[1] && en_q[6] && !en_q[5];
   endproperty
   a_up_slot1: assert property (p_up_slot1) else $error("up slot 1 wrong"); // see R11

   property p_down_slot1;
      @(posedge ref_clk) disable iff (!rst_sync_n)
      in_down && slot_q == 3'h1 |=> !en_q[1] && !en_q[5] && !en_q[6];
   endproperty
   a_down_slot1: assert property (p_down_slot1) else $error("down slot 1 wrong"); // see R12

   property p_slot_step;
      @(posedge ref_clk) disable iff (!rst_sync_n)
      in_seq && slot_end && !seq_done && state_d == state_q |=>
         slot_q == $past(slot_q) + 3'h1 && tmr_q == '0;
   endproperty
   a_slot_step: assert property (p_slot_step) else $error("slot step wrong"); // see R15

   property p_slp_keep;
      @(posedge ref_clk) disable iff (!rst_sync_n)
      (in_entry || in_exit) |=> en_q[0] == $past(en_q[0]) && en_q[4] == $past(en_q[4]);
   endproperty
   a_slp_keep: assert property (p_slp_keep) else $error("unsequenced rail moved"); // see R13 see R14

endmodule // rsmfc_ctrl

// ---- rsmfc_pkg.sv ----
package rsmfc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Sizes
   localparam int unsigned RAILS = 8;
   localparam int unsigned SLOT_W = 3;
   localparam int unsigned TMR_W = 14;

   ////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam int unsigned SLOT_US = 625;
   localparam int unsigned SLOT_CYC = (SLOT_US * 1000) / CLK_PERIOD_NS;

   ////////////////////////////////////////////////////////////////////////////
   // Slot positions, element [0] is rail 1, position 0 means never touched
   typedef logic [RAILS-1:0][SLOT_W-1:0] rsmfc_pos_type;
   localparam rsmfc_pos_type POS_UP = {3'h2, 3'h1, 3'h4, 3'h3, 3'h2, 3'h2, 3'h1, 3'h1};
   localparam rsmfc_pos_type POS_DOWN = {3'h3, 3'h1, 3'h1, 3'h2, 3'h3, 3'h3, 3'h1, 3'h4};
   localparam rsmfc_pos_type POS_EXIT = {3'h3, 3'h1, 3'h2, 3'h0, 3'h0, 3'h3, 3'h1, 3'h0};
   localparam rsmfc_pos_type POS_ENTRY = {3'h2, 3'h3, 3'h1, 3'h0, 3'h0, 3'h2, 3'h3, 3'h0};
   localparam logic [SLOT_W-1:0] SLOT_FIRST = 3'h1;
   localparam logic [SLOT_W-1:0] SLOT_LAST_PWR = 3'h4;
   localparam logic [SLOT_W-1:0] SLOT_LAST_SLP = 3'h3;

   ////////////////////////////////////////////////////////////////////////////
   // Fault flag layout of the first flag byte
   localparam int unsigned FLG_EXT_RST = 0;
   localparam int unsigned FLG_EMERG = 1;
   localparam int unsigned FLG_SEQ = 2;
   localparam logic [7:0] FLAGS_RST = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [2:0] {
      ST_OFF = 3'h0,
      ST_UP = 3'h1,
      ST_ACTIVE = 3'h2,
      ST_DOWN = 3'h3,
      ST_SLP_IN = 3'h4,
      ST_SLEEP = 3'h5,
      ST_SLP_OUT = 3'h6
   } rsmfc_state_type;

   typedef struct packed {
      logic run;
      logic sleep_n;
      logic emerg_n;
   } rsmfc_ctrl_type;

endpackage : rsmfc_pkg

// ---- rsmfc_partner.sv ----
module rsmfc_partner (
   // Clock
   input wire logic ref_clk,
   // Converter side
   input wire logic [rsmfc_pkg::RAILS-1:0] rail_enable,
   input wire logic [rsmfc_pkg::RAILS-1:0] fail_mask,
   output logic [rsmfc_pkg::RAILS-1:0] rail_pgood,
   // Outside party on the reset wire
   input wire logic pull_reset,
   output logic reset_pull_oe
);
   timeunit 1ns;
   timeprecision 1ns;

   initial rail_pgood = 8'h00;

   // Converters report good one cycle late; a failing rail never reports
   always @(posedge ref_clk) begin
      rail_pgood <= rail_enable & ~fail_mask;
   end

   assign reset_pull_oe = pull_reset;

endmodule // rsmfc_partner

// ---- rsmfc_ctrl_bench.sv ----
module rsmfc_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ns;

   localparam int SLOTS = 8;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic run = 1'b0;
   logic sleep_n = 1'b1;
   logic emerg_n = 1'b1;
   logic pull_reset = 1'b0;
   logic [7:0] fail_mask = 8'h00;
   logic [7:0] clr1 = 8'h00;
   logic [7:0] clr2 = 8'h00;
   logic [7:0] rail_enable;
   logic [7:0] rail_pgood;
   logic [7:0] flags1;
   logic [7:0] flags2;
   logic sr_oe;
   logic sr_out;
   logic irq_oe;
   logic irq_out;
   logic pull_oe;
   wire sr_wire;
   int num_errors = 0;
   int comparisons = 0;
   int cycles = 0;

   // Pull-up on the reset wire; any driver pulls it low
   assign sr_wire = !((sr_oe && !sr_out) || pull_oe);

   always #20 ref_clk = ~ref_clk;

   rsmfc_ctrl #(.SLOT_CYCLES(SLOTS)) DUT (
      .ref_clk(ref_clk), .rst_n(rst_n), .run_request_in(run), .sleep_n_in(sleep_n),
      .emergency_powerdown_n(emerg_n), .rail_enable(rail_enable), .rail_pgood(rail_pgood),
      .system_reset_n_in(sr_wire), .system_reset_n_out(sr_out), .system_reset_n_oe(sr_oe),
      .fault_irq_n_out(irq_out), .fault_irq_n_oe(irq_oe), .fault_flags_first(flags1),
      .fault_flags_second(flags2), .clear_flags_first(clr1), .clear_flags_second(clr2)
   );

   rsmfc_partner partner (
      .ref_clk(ref_clk), .rail_enable(rail_enable), .fail_mask(fail_mask),
      .rail_pgood(rail_pgood), .pull_reset(pull_reset), .reset_pull_oe(pull_oe)
   );

   ////////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         end_sim();
      end
   end

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Walks one sequence; each slot after the first must land exactly one slot time after the last
   task automatic seq(input logic [7:0] e[4], input int n);
      logic [7:0] prev;
      int gap;
      prev = rail_enable;
      for (int i = 0; i < n; i++) begin
         gap = 0;
         while (rail_enable === prev && gap < 40) begin
            @(negedge ref_clk);
            gap++;
         end
         check("rails", rail_enable, e[i]);
         if (i == 0) check("lead", 8'(gap >= 3 && gap <= 6), 8'h01);
         else check("slot gap", 8'(gap), 8'(SLOTS));
         prev = rail_enable;
      end
      // Let the state machine settle before the next request
      repeat (SLOTS + 2) @(negedge ref_clk);
   endtask

   task automatic clear(input logic [7:0] c1, input logic [7:0] c2);
      @(negedge ref_clk);
      clr1 = c1;
      clr2 = c2;
      @(negedge ref_clk);
      clr1 = 8'h00;
      clr2 = 8'h00;
      repeat (2) @(negedge ref_clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_up;
      @(negedge ref_clk);
      run = 1'b1;
      seq('{8'h43, 8'hCF, 8'hDF, 8'hFF}, 4);
      check("reset drive", 8'(sr_oe), 8'h00);
      check("flags", flags1 | flags2, 8'h00);
      check("open drain data", 8'({sr_out, irq_out}), 8'h00);
   endtask

   task automatic t_sleep;
      @(negedge ref_clk);
      sleep_n = 1'b0;
      seq('{8'hDF, 8'h5B, 8'h19, 8'h00}, 3);
      @(negedge ref_clk);
      sleep_n = 1'b1;
      seq('{8'h5B, 8'h7B, 8'hFF, 8'h00}, 3);
   endtask

   task automatic t_ext_reset;
      @(negedge ref_clk);
      pull_reset = 1'b1;
      repeat (3) @(negedge ref_clk);
      pull_reset = 1'b0;
      repeat (2) @(negedge ref_clk);
      check("ext flag", flags1, 8'h01);
      check("irq", 8'(irq_oe), 8'h01);
      clear(8'hFE, 8'hFF);
      check("zero write", flags1, 8'h01);
      repeat (6) @(negedge ref_clk);
      check("held flag", flags1, 8'h01);
      clear(8'h01, 8'h00);
      check("cleared", flags1, 8'h00);
      check("irq off", 8'(irq_oe), 8'h00);
   endtask

   task automatic t_emergency;
      @(negedge ref_clk);
      emerg_n = 1'b0;
      seq('{8'h9D, 8'h8D, 8'h01, 8'h00}, 4);
      check("emerg flag", flags1, 8'h02);
      repeat (12) @(negedge ref_clk);
      check("no restart", rail_enable, 8'h00);
      fail_mask = 8'h10;
      emerg_n = 1'b1;
      seq('{8'h43, 8'hCF, 8'hDF, 8'hFF}, 4);
      check("pgood rail", flags2, 8'h10);
      check("summary", flags1, 8'h06);
      check("irq", 8'(irq_oe), 8'h01);
      fail_mask = 8'h00;
      clear(8'h02, 8'h00);
      check("partial", flags1, 8'h04);
      clear(8'h04, 8'h10);
      check("all clear", flags1 | flags2, 8'h00);
      check("irq off", 8'(irq_oe), 8'h00);
   endtask

   // Reset in mid-run must drop every rail and flag, then allow a clean power-up
   task automatic t_mid_reset;
      @(negedge ref_clk);
      pull_reset = 1'b1;
      @(negedge ref_clk);
      pull_reset = 1'b0;
      check("ext flag", flags1, 8'h01);
      rst_n = 1'b0;
      run = 1'b0;
      @(negedge ref_clk);
      check("reset rails", rail_enable, 8'h00);
      check("reset flags", flags1 | flags2, 8'h00);
      check("reset irq", 8'(irq_oe), 8'h00);
      check("reset drive", 8'(sr_oe), 8'h01);
      rst_n = 1'b1;
      repeat (4) @(negedge ref_clk);
      t_up();
   endtask

   task automatic t_run_low;
      @(negedge ref_clk);
      run = 1'b0;
      seq('{8'h9D, 8'h8D, 8'h01, 8'h00}, 4);
      check("reset drive", 8'(sr_oe), 8'h01);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(negedge ref_clk);
      rst_n = 1'b1;
      repeat (4) @(negedge ref_clk);
      t_up();
      t_sleep();
      t_ext_reset();
      t_emergency();
      t_mid_reset();
      t_run_low();
      end_sim();
   end

endmodule // rsmfc_ctrl_bench
